// ==== design/seqprog_erase.v ====
// serial flash command sequencer: sequential byte program and block erase
`timescale 1ns/1ps
`include "seqprog_erase_defines.vh"

// overview of the sequencer
// - pins arrive unsynchronised and pass three stages
// - a filtered level feeds the edge detectors
// - bits shift in on filtered sck rise while selected
// - byte zero is the opcode, bytes one to three the address outside sequential mode
// - later bytes only refresh the data latch
// - every command is decided at the filtered chip select rise
// - the array engine outside reports done and fail
// - busy gates every command until done arrives
// limitations
// - no status read here; the host polls busy elsewhere
// - no byte program or erase timers; array timing is external
// - sector map fixed: fifteen large, one 16k, two 8k, one top
// - upper address nibble is dropped: 20-bit array

module seqprog_erase (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_cs_n,
    input wire i_sck,
    input wire i_si,
    input wire [18:0] i_sector_prot,
    input wire i_array_done,
    input wire i_array_fail,
    output reg o_prog_start,
    output reg [19:0] o_prog_addr,
    output reg [7:0] o_prog_data,
    output reg o_erase_start,
    output reg [19:0] o_erase_addr,
    output reg [1:0] o_erase_size,
    output reg o_busy,
    output reg o_write_enable_latch,
    output reg o_program_erase_error_flag,
    output reg o_seq_mode
);

    // sector index of an array address; indices rise with the address
    function [4:0] sector_of;
        input [19:0] a;
        begin
            if (a[19:16] != `TOP_REGION)
                sector_of = {1'b0, a[19:16]};
            else if (a[15])
                sector_of = `SECT_BOOT;
            else if (!a[14])
                sector_of = `SECT_16K;
            else if (!a[13])
                sector_of = `SECT_8K_LO;
            else
                sector_of = `SECT_8K_HI;
        end
    endfunction

    // pin synchronisers: cs_n, sck, si in bits 2..0
    // reset to idle-high so no false chip select edge follows reset
    // sck idles low in mode 0: its first move after reset is a fall,
    // which the rise detector ignores
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg [2:0] sync3_reg;
    reg [2:0] filt_reg;
    reg [2:0] filt_next;
    reg sck_prev_reg;
    reg cs_prev_reg;

    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            sync3_reg <= 3'h7;
        end else begin
            sync1_reg <= {i_cs_n, i_sck, i_si};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a level change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_filt
            always @* begin
                filt_next[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : filt_reg[g];
            end
        end
    endgenerate

    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            filt_reg <= 3'h7;
            sck_prev_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            filt_reg <= filt_next;
            sck_prev_reg <= filt_reg[1];
            cs_prev_reg <= filt_reg[2];
        end
    end

    wire cs_low = ~filt_reg[2];
    wire sck_rise = filt_reg[1] & ~sck_prev_reg;
    wire cs_rise = filt_reg[2] & ~cs_prev_reg;
    wire cs_fall = ~filt_reg[2] & cs_prev_reg;
    wire si_bit = filt_reg[0];

    // serial shifter with bit and byte counters
    reg [6:0] shift_reg;
    reg [2:0] bitcnt_reg;
    reg [2:0] bytecnt_reg;
    reg [7:0] opcode_reg;
    reg [23:0] addr_reg;
    reg [7:0] data_reg;
    wire [7:0] byte_in = {shift_reg, si_bit};

    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            shift_reg <= 7'h00;
            bitcnt_reg <= 3'h0;
            bytecnt_reg <= 3'h0;
            opcode_reg <= 8'h00;
            addr_reg <= 24'h000000;
            data_reg <= 8'h00;
        end else if (cs_fall) begin
            bitcnt_reg <= 3'h0;
            bytecnt_reg <= 3'h0;
            // stale opcode must not act again on an empty frame
            opcode_reg <= 8'h00;
        end else if (cs_low && sck_rise) begin
            shift_reg <= byte_in[6:0];
            bitcnt_reg <= bitcnt_reg + 3'h1;
            if (bitcnt_reg == `BIT_LAST) begin
                // saturate: extra bytes only overwrite the data latch
                if (bytecnt_reg != `BYTES_MAX)
                    bytecnt_reg <= bytecnt_reg + 3'h1;
                if (bytecnt_reg == 3'h0)
                    opcode_reg <= byte_in;
                else if (!o_seq_mode && bytecnt_reg < `BYTES_ADDR)
                    addr_reg <= {addr_reg[15:0], byte_in};
                // every later complete byte replaces the last one
                if (o_seq_mode || bytecnt_reg >= `BYTES_ADDR)
                    data_reg <= byte_in;
            end
        end
    end

    // opcode classes
    wire op_seq = (opcode_reg == `OP_SEQ_A) || (opcode_reg == `OP_SEQ_B);
    wire op_4k = (opcode_reg == `OP_ERASE_4K);
    wire op_32k = (opcode_reg == `OP_ERASE_32K);
    wire op_64k = (opcode_reg == `OP_ERASE_64K);
    wire op_erase = op_4k | op_32k | op_64k;
    wire on_boundary = (bitcnt_reg == 3'h0);

    // block bounds with the ignored low bits masked off
    reg [19:0] erase_mask;
    reg [1:0] erase_size;
    always @* begin
        erase_mask = `MASK_4K;
        erase_size = `SIZE_4K;
        if (op_32k) begin
            erase_mask = `MASK_32K;
            erase_size = `SIZE_32K;
        end else if (op_64k) begin
            erase_mask = `MASK_64K;
            erase_size = `SIZE_64K;
        end
    end
    wire [19:0] blk_lo = addr_reg[19:0] & ~erase_mask;
    wire [19:0] blk_hi = blk_lo | erase_mask;
    wire [4:0] sect_lo = sector_of(blk_lo);
    wire [4:0] sect_hi = sector_of(blk_hi);

    // any protected sector inside the erase span
    // sectors are contiguous in index order, so the span is a range
    // one comparator pair per sector; cheap next to a lookup table
    wire [18:0] span_hit;
    generate
        for (g = 0; g < `NUM_SECTORS; g = g + 1) begin : g_span
            assign span_hit[g] = i_sector_prot[g] && (g >= sect_lo) && (g <= sect_hi);
        end
    endgenerate
    wire span_prot = |span_hit;

    // sequential counter lookahead for the automatic exit
    reg [19:0] seq_addr_reg;
    wire [19:0] seq_next = seq_addr_reg + 20'h00001;
    wire start_prot = i_sector_prot[sector_of(addr_reg[19:0])];
    wire [19:0] first_next = addr_reg[19:0] + 20'h00001;
    // exit once the programmed byte is the top or the next sits protected
    wire first_last = (addr_reg[19:0] == `ARRAY_TOP) || i_sector_prot[sector_of(first_next)];
    // the byte after the one now programmed decides the exit
    wire [19:0] seq_after = seq_addr_reg + 20'h00002;
    wire cont_last = (seq_next == `ARRAY_TOP) || i_sector_prot[sector_of(seq_after)];

    // command execution at chip select release
    // priority: write enable, write disable, sequential, erase
    // in sequential mode erase opcodes fall through and are ignored
    // start pulses last one cycle; addr, data and size stay put
    // the error flag clears only when a new operation starts,
    // so a host can read it after busy drops
    // set of the error flag cannot meet a clear: starts need !busy
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_seq_mode <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_busy <= 1'b0;
            o_program_erase_error_flag <= 1'b0;
            o_prog_start <= 1'b0;
            o_prog_addr <= 20'h00000;
            o_prog_data <= 8'h00;
            o_erase_start <= 1'b0;
            o_erase_addr <= 20'h00000;
            o_erase_size <= `SIZE_4K;
            seq_addr_reg <= 20'h00000;
        end else begin
            o_prog_start <= 1'b0;
            o_erase_start <= 1'b0;
            // array completion; a failure flags, no new start shares this cycle
            if (o_busy && i_array_done) begin
                o_busy <= 1'b0;
                if (i_array_fail)
                    o_program_erase_error_flag <= 1'b1;
            end
            // commands arriving while busy are dropped
            if (cs_rise && !o_busy) begin
                if (opcode_reg == `OP_WREN && bytecnt_reg >= `BYTES_OP && on_boundary) begin
                    o_write_enable_latch <= 1'b1;
                end else if (opcode_reg == `OP_WRDI && bytecnt_reg >= `BYTES_OP
                    && on_boundary) begin
                    o_write_enable_latch <= 1'b0;
                    o_seq_mode <= 1'b0;
                end else if (op_seq && o_seq_mode) begin
                    if (bytecnt_reg >= `BYTES_SEQ_NEXT && on_boundary) begin
                        o_prog_start <= 1'b1;
                        o_prog_addr <= seq_next;
                        o_prog_data <= data_reg;
                        o_busy <= 1'b1;
                        o_program_erase_error_flag <= 1'b0;
                        seq_addr_reg <= seq_next;
                        if (cont_last) begin
                            o_seq_mode <= 1'b0;
                            o_write_enable_latch <= 1'b0;
                        end
                    end else begin
                        // ragged cycle: nothing programmed
                        o_write_enable_latch <= 1'b0;
                        o_seq_mode <= 1'b0;
                    end
                end else if (op_seq && o_write_enable_latch && !o_seq_mode) begin
                    if (!(bytecnt_reg >= `BYTES_SEQ_FIRST && on_boundary)) begin
                        o_write_enable_latch <= 1'b0;
                    end else if (start_prot) begin
                        o_write_enable_latch <= 1'b0;
                    end else begin
                        o_prog_start <= 1'b1;
                        o_prog_addr <= addr_reg[19:0];
                        o_prog_data <= data_reg;
                        o_busy <= 1'b1;
                        o_program_erase_error_flag <= 1'b0;
                        seq_addr_reg <= addr_reg[19:0];
                        if (first_last)
                            o_write_enable_latch <= 1'b0;
                        else
                            o_seq_mode <= 1'b1;
                    end
                end else if (op_erase && o_write_enable_latch && !o_seq_mode) begin
                    if (!(bytecnt_reg >= `BYTES_ADDR && on_boundary)) begin
                        o_write_enable_latch <= 1'b0;
                    end else if (span_prot) begin
                        o_write_enable_latch <= 1'b0;
                    end else begin
                        o_erase_start <= 1'b1;
                        o_erase_addr <= blk_lo;
                        o_erase_size <= erase_size;
                        o_busy <= 1'b1;
                        o_program_erase_error_flag <= 1'b0;
                        // latch drops at the start, well before the erase ends
                        o_write_enable_latch <= 1'b0;
                    end
                end
            end
        end
    end

endmodule // seqprog_erase

// ==== design/seqprog_erase_defines.vh ====
// constants for the sequential program and block erase sequencer
// Behaviour
// - program failure sets program/erase error flag
// - reset returns to byte/page program mode
// - sequential entry needs write enable latch set
// - entry: opcode, three address bytes, data
// - later cycles: opcode, data, next address
// - write disable clears latch, leaves sequential
// - only last complete data byte is programmed
// - short or ragged cycle aborts, clears latch
// - protected start address refused, latch cleared
// - no wrap: exit after top array byte
// - exit before protected sector, latch cleared
// - busy shown while byte programs
// - decode 4K, 32K, 64K block erase opcodes
// - block erase needs write enable latch
// - opcode plus three address bytes, extras ignored
// - low address bits ignored per block size
// - short or ragged erase aborts, nothing erased
// - any protected sector in block rejects erase
// - rejected erase clears write enable latch
// - busy during erase, latch cleared early
// - erase failure sets program/erase error flag
// - write enable opcode sets latch on boundary
// - write disable opcode clears latch on boundary
`ifndef SEQPROG_ERASE_DEFINES_VH
`define SEQPROG_ERASE_DEFINES_VH

`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_SEQ_A 8'had
`define OP_SEQ_B 8'haf
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8

`define SIZE_4K 2'h0
`define SIZE_32K 2'h1
`define SIZE_64K 2'h2

`define MASK_4K 20'h00fff
`define MASK_32K 20'h07fff
`define MASK_64K 20'h0ffff

`define ARRAY_TOP 20'hfffff
`define NUM_SECTORS 19
`define TOP_REGION 4'hf
`define SECT_16K 5'h0f
`define SECT_8K_LO 5'h10
`define SECT_8K_HI 5'h11
`define SECT_BOOT 5'h12

`define BYTES_OP 3'h1
`define BYTES_ADDR 3'h4
`define BYTES_SEQ_FIRST 3'h5
`define BYTES_SEQ_NEXT 3'h2
`define BYTES_MAX 3'h7
`define BIT_LAST 3'h7

`endif

// ==== sim/seqprog_erase_monitor.sv ====
// concurrent checks on the sequencer top ports
`timescale 1ns/1ps
module seqprog_erase_monitor (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_cs_n,
    input wire i_array_done,
    input wire i_array_fail,
    input wire o_prog_start,
    input wire o_erase_start,
    input wire [19:0] o_erase_addr,
    input wire [1:0] o_erase_size,
    input wire o_busy,
    input wire o_write_enable_latch,
    input wire o_program_erase_error_flag,
    input wire o_seq_mode
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // an operation launched, and an operation finishing
    sequence s_start; o_prog_start || o_erase_start; endsequence
    sequence s_done; o_busy && i_array_done; endsequence
    a_start_shows_busy: assert property (s_start |-> o_busy)
        else $error("start pulse without busy");
    a_start_one_cycle: assert property (s_start |=> !o_prog_start && !o_erase_start)
        else $error("start pulse longer than one cycle");
    a_busy_holds_until: assert property (o_busy && !i_array_done |=> o_busy)
        else $error("busy dropped before done");
    a_done_drops_busy: assert property (s_done |=> !o_busy)
        else $error("busy stayed after done");
    a_fail_sets_flag: assert property (s_done ##0 i_array_fail |=> o_program_erase_error_flag)
        else $error("failure not flagged");
    a_erase_drops_wel: assert property (o_erase_start |-> !o_write_enable_latch)
        else $error("latch set during erase");
    a_erase_size_ok: assert property (o_erase_start |-> o_erase_size != 2'h3)
        else $error("bad erase size");
    // base address must have the size's low bits cleared
    a_erase_base_mask: assert property (o_erase_start |-> (o_erase_addr & (o_erase_size == 2'h0 ?
        20'h00fff : o_erase_size == 2'h1 ? 20'h07fff : 20'h0ffff)) == 20'h0)
        else $error("erase base not aligned");
    a_seq_needs_wel: assert property ($rose(o_seq_mode) |-> $past(o_write_enable_latch))
        else $error("sequential entry without latch");
    a_start_after_cs: assert property (s_start |-> i_cs_n && $past(i_cs_n, 3))
        else $error("start while selected");
endmodule // seqprog_erase_monitor
bind seqprog_erase seqprog_erase_monitor seqprog_erase_monitor_i (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_cs_n(i_cs_n),
    .i_array_done(i_array_done),
    .i_array_fail(i_array_fail),
    .o_prog_start(o_prog_start),
    .o_erase_start(o_erase_start),
    .o_erase_addr(o_erase_addr),
    .o_erase_size(o_erase_size),
    .o_busy(o_busy),
    .o_write_enable_latch(o_write_enable_latch),
    .o_program_erase_error_flag(o_program_erase_error_flag),
    .o_seq_mode(o_seq_mode)
);

// ==== sim/spi_host_model.sv ====
// spi host: frames msb first, sck still and low between frames
`timescale 1ns/1ps
module spi_host_model (
    input wire i_core_clk,
    output reg o_cs_n,
    output reg o_sck,
    output reg o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    // n bits of d from the top; n off a byte multiple gives a ragged frame
    task send(input [39:0] d, input integer n);
        integer k;
        begin
            @(posedge i_core_clk);
            o_cs_n <= 1'b0;
            repeat (4) @(posedge i_core_clk);
            for (k = 0; k < n; k = k + 1) begin
                // 125 ns sck period; every eighth sck fall lands on a core clock edge
                o_si <= d[39 - k];
                #62.5;
                o_sck <= 1'b1;
                #62.5;
                o_sck <= 1'b0;
            end
            repeat (4) @(posedge i_core_clk);
            o_cs_n <= 1'b1;
            o_si <= ~o_si; // released line keeps no stale value
            repeat (8) @(posedge i_core_clk);
        end
    endtask
endmodule // spi_host_model

// ==== sim/tb_top.sv ====
// self-checking bench for the sequential program and block erase sequencer
`timescale 1ns/1ps
`include "seqprog_erase_defines.vh"
module tb_top;
    reg i_core_clk, i_nrst, i_array_done, i_array_fail, fail_next;
    reg [18:0] i_sector_prot;
    wire cs_n, sck, si, o_prog_start, o_erase_start, o_busy, write_enable_latch, err, seq;
    wire [19:0] o_prog_addr, o_erase_addr;
    wire [7:0] o_prog_data;
    wire [1:0] o_erase_size;
    reg [19:0] pa, ea, a, m;
    reg [7:0] pd, d, op;
    reg [1:0] es;
    integer np, ne, n0, dly, fails, total_checks, j;
    spi_host_model spi_host_model_i (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sck(sck),
        .o_si(si));
    seqprog_erase seqprog_erase_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .i_sector_prot(i_sector_prot), .i_array_done(i_array_done),
        .i_array_fail(i_array_fail), .o_prog_start(o_prog_start), .o_prog_addr(o_prog_addr),
        .o_prog_data(o_prog_data), .o_erase_start(o_erase_start), .o_erase_addr(o_erase_addr),
        .o_erase_size(o_erase_size), .o_busy(o_busy), .o_write_enable_latch(write_enable_latch),
        .o_program_erase_error_flag(err), .o_seq_mode(seq));
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    // array stand-in: done four cycles after a start; records what was started
    always @(posedge i_core_clk) begin
        i_array_done <= 1'b0;
        if (dly == 1) begin
            i_array_done <= 1'b1;
            i_array_fail <= fail_next;
        end
        if (dly != 0) dly <= dly - 1;
        if (o_prog_start === 1'b1) begin
            np <= np + 1;
            pa <= o_prog_addr;
            pd <= o_prog_data;
            dly <= 4;
        end
        if (o_erase_start === 1'b1) begin
            ne <= ne + 1;
            ea <= o_erase_addr;
            es <= o_erase_size;
            dly <= 4;
        end
    end
    task complete_run;
        begin
            if (fails == 0 && total_checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [19:0] e, input [19:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // one frame, then poll busy under a bound instead of a worst-case wait
    task cmd(input [39:0] v, input integer n);
        integer k;
        begin
            spi_host_model_i.send(v, n);
            k = 0;
            while (o_busy !== 1'b0 && k < 300) begin
                @(posedge i_core_clk);
                k = k + 1;
            end
            if (k == 300) begin
                fails = fails + 1;
                complete_run;
            end
        end
    endtask
    task wren;
        cmd({`OP_WREN, 32'h0}, 8);
    endtask
    initial begin
        i_nrst = 1'b0;
        i_array_done = 1'b0;
        i_array_fail = 1'b0;
        fail_next = 1'b0;
        i_sector_prot = 19'h0;
        {np, ne, dly, fails, total_checks} = 0;
        j = $urandom(54396);
        repeat (6) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        @(posedge i_core_clk);
        chk("seq", 20'h0, seq);
        chk("wel", 20'h0, write_enable_latch);
        a = $urandom & 20'h0ff00;
        d = $urandom;
        cmd({`OP_SEQ_A, 4'h0, a, d}, 40);
        chk("np", 20'h0, np[19:0]);
        cmd({`OP_WREN, 32'h0}, 7);
        chk("wel", 20'h0, write_enable_latch);
        wren;
        chk("wel", 20'h1, write_enable_latch);
        cmd({`OP_SEQ_A, 4'h0, a, d}, 40);
        chk("pa", a, pa);
        chk("pd", d, pd);
        chk("seq", 20'h1, seq);
        cmd({`OP_SEQ_B, d, ~d, 16'h0}, 24);
        chk("pa", a + 20'h1, pa);
        chk("pd", d ^ 8'hff, pd);
        cmd({`OP_SEQ_B, d, 24'h0}, 12);
        chk("np", 20'h2, np[19:0]);
        chk("wel", 20'h0, write_enable_latch);
        wren;
        cmd({`OP_SEQ_A, 4'h0, a, d}, 40);
        cmd({`OP_WRDI, 32'h0}, 8);
        chk("wel", 20'h0, write_enable_latch);
        chk("seq", 20'h0, seq);
        i_sector_prot <= 19'h00002;
        wren;
        cmd({`OP_SEQ_A, 4'h0, 20'h0fffe, d}, 40);
        cmd({`OP_SEQ_B, d, 24'h0}, 16);
        chk("pa", 20'h0ffff, pa);
        chk("seq", 20'h0, seq);
        chk("wel", 20'h0, write_enable_latch);
        n0 = np;
        wren;
        cmd({`OP_SEQ_A, 4'h0, 20'h10000 | a, d}, 40);
        chk("np", n0[19:0], np[19:0]);
        chk("wel", 20'h0, write_enable_latch);
        wren;
        cmd({`OP_SEQ_A, 4'h0, 20'hfffff, d}, 40);
        chk("pa", 20'hfffff, pa);
        chk("seq", 20'h0, seq);
        fail_next <= 1'b1;
        wren;
        cmd({`OP_SEQ_A, 4'h0, a, d}, 40);
        chk("err", 20'h1, err);
        // mid-run reset while still in sequential mode
        i_nrst <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        chk("seq", 20'h0, seq);
        chk("wel", 20'h0, write_enable_latch);
        chk("err", 20'h0, err);
        i_sector_prot <= 19'h0;
        for (j = 0; j < 3; j = j + 1) begin
            op = j == 0 ? `OP_ERASE_4K : j == 1 ? `OP_ERASE_32K : `OP_ERASE_64K;
            m = j == 0 ? `MASK_4K : j == 1 ? `MASK_32K : `MASK_64K;
            a = $urandom;
            fail_next <= (j == 1);
            wren;
            cmd({op, 4'h0, a, 8'h5a}, 32 + 8 * (j == 2));
            chk("ea", a & ~m, ea);
            chk("es", j, es);
            chk("wel", 20'h0, write_enable_latch);
            chk("err", (j == 1), err);
        end
        n0 = ne;
        cmd({`OP_ERASE_4K, 4'h0, a, 8'h0}, 32);
        chk("ne", n0[19:0], ne[19:0]);
        wren;
        cmd({`OP_ERASE_4K, 4'h0, a, 8'h0}, 20);
        chk("ne", n0[19:0], ne[19:0]);
        chk("wel", 20'h0, write_enable_latch);
        i_sector_prot <= 19'h08000;
        wren;
        cmd({`OP_ERASE_64K, 4'h0, 20'hf1234, 8'h0}, 32);
        chk("ne", n0[19:0], ne[19:0]);
        chk("wel", 20'h0, write_enable_latch);
        complete_run;
    end
endmodule // tb_top
